// ---- hw/tpx_terminal.sv ----
// Operator terminal end of the controller status exchange.
// Assumes the link answers every request with one rsp_valid pulse.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module tpx_terminal (
   input wire logic clock_i,
   input wire logic reset_n_i,
   tpx_link_if.terminal link,
   input wire logic [15:0] cmd_base_i,
   input wire logic [15:0] rpt_base_i,
   input wire logic [15:0] elem_base_i,
   input wire logic [15:0] num_base_i,
   input wire logic [15:0] str_base_i,
   input wire logic [15:0] key_addr_i,
   input wire logic [13:0] state_bits_i,
   input wire logic num_key_valid_i,
   input wire logic [6:0] num_key_entry_i,
   input wire logic [15:0] num_key_value_i,
   output logic num_key_ready_o,
   input wire logic str_edit_valid_i,
   input wire logic [6:0] str_edit_entry_i,
   input wire logic [15:0] str_edit_value_i,
   output logic str_edit_ready_o,
   input wire logic sys_key_valid_i,
   input wire logic [15:0] sys_key_code_i,
   output logic sys_key_ready_o,
   output logic [15:0] screen_o,
   output logic screen_change_o,
   output logic backlight_o,
   output logic copy_start_o,
   output logic copy_type_o,
   output logic [6:0] copy_entry_o,
   output logic elem_update_o,
   output logic [1:0] elem_index_o,
   output logic [15:0] elem_data_o
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_REQ = 4'b0010,
      ST_WAIT = 4'b0100,
      ST_APPLY = 4'b1000
   } tpx_state_t;

   typedef enum logic [2:0] {
      OP_CMD, OP_ELEM, OP_NUMW, OP_STRW, OP_KEYW, OP_RPT0, OP_RPT1, OP_RPT2
   } tpx_op_t;

   tpx_state_t state_q;
   tpx_op_t op_q, sel_op;
   logic [1:0] idx_q;
   logic [15:0] addr_q, wdata_q, sel_addr, sel_wdata, poll_cnt_q;
   logic write_q, sel_go, ack, poll_due;
   logic [15:0] cmd_q [tpx_pkg::CMD_WORDS];
   logic [15:0] copy_entry_prev_q, copy_type_prev_q;
   logic num_pend_q, str_pend_q, key_pend_q;
   logic rpt0_pend_q, rpt1_pend_q, stat_pend_q;
   logic [6:0] num_entry_q, str_entry_q, rpt_entry_q;
   logic [15:0] num_val_q, str_val_q, key_code_q;
   logic [1:0] strobe_q, sent_q;
   logic [13:0] state_last_q;
   logic scr_new, state_change;

   assign link.req_valid = (state_q == ST_REQ);
   assign link.req_write = write_q;
   assign link.req_addr = addr_q;
   assign link.req_wdata = wdata_q;
   assign ack = (state_q == ST_WAIT) && link.rsp_valid;
   assign poll_due = (poll_cnt_q == tpx_pkg::POLL_LAST);
   assign num_key_ready_o = !num_pend_q && !rpt1_pend_q;
   assign str_edit_ready_o = !str_pend_q;
   assign sys_key_ready_o = !key_pend_q;
   assign scr_new = (state_q == ST_APPLY) && (cmd_q[0] != screen_o);
   assign state_change = (state_bits_i != state_last_q);

   ////////////////////////////////////////////////////////////////////////
   // Next link operation, highest priority first

   always_comb begin
      sel_go = 1'b1;
      sel_op = OP_CMD;
      sel_addr = tpx_pkg::word_addr(cmd_base_i, tpx_pkg::CMD_SCREEN);
      sel_wdata = tpx_pkg::WORD_ZERO;
      if (num_pend_q && !rpt1_pend_q) begin
         sel_op = OP_NUMW;
         sel_addr = tpx_pkg::word_addr(num_base_i, {9'h000, num_entry_q});
         sel_wdata = num_val_q;
      end else if (rpt0_pend_q) begin
         sel_op = OP_RPT0;
         sel_addr = tpx_pkg::word_addr(rpt_base_i, tpx_pkg::RPT_SCREEN);
         sel_wdata = screen_o;
      end else if (rpt1_pend_q) begin
         sel_op = OP_RPT1;
         sel_addr = tpx_pkg::word_addr(rpt_base_i, tpx_pkg::RPT_ENTRY);
         sel_wdata = {9'h000, rpt_entry_q};
      end else if (stat_pend_q) begin
         sel_op = OP_RPT2;
         sel_addr = tpx_pkg::word_addr(rpt_base_i, tpx_pkg::RPT_STATUS);
         sel_wdata = {state_bits_i, strobe_q};
      end else if (str_pend_q) begin
         sel_op = OP_STRW;
         sel_addr = tpx_pkg::word_addr(str_base_i, {9'h000, str_entry_q});
         sel_wdata = str_val_q;
      end else if (key_pend_q) begin
         sel_op = OP_KEYW;
         sel_addr = key_addr_i;
         sel_wdata = key_code_q;
      end else if (!poll_due) begin
         sel_go = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link sequencer

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= ST_IDLE;
         op_q <= OP_CMD;
         idx_q <= 2'h0;
         addr_q <= tpx_pkg::WORD_ZERO;
         wdata_q <= tpx_pkg::WORD_ZERO;
         write_q <= 1'b0;
         poll_cnt_q <= tpx_pkg::WORD_ZERO;
      end else begin
         if (!poll_due) begin
            poll_cnt_q <= poll_cnt_q + 16'h0001;
         end
         case (state_q)
            ST_IDLE: begin
               if (sel_go) begin
                  op_q <= sel_op;
                  idx_q <= 2'h0;
                  addr_q <= sel_addr;
                  wdata_q <= sel_wdata;
                  write_q <= (sel_op != OP_CMD);
                  state_q <= ST_REQ;
                  if (sel_op == OP_CMD) begin
                     poll_cnt_q <= tpx_pkg::WORD_ZERO;
                  end
               end
            end
            ST_REQ: begin
               if (link.req_ready) begin
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (ack) begin
                  state_q <= ST_IDLE;
                  if (op_q == OP_CMD || op_q == OP_ELEM) begin
                     idx_q <= idx_q + 2'h1;
                     addr_q <= addr_q + 16'h0001;
                     state_q <= ST_REQ;
                     if (idx_q == tpx_pkg::ELEM_LAST) begin
                        state_q <= (op_q == OP_CMD) ? ST_APPLY : ST_IDLE;
                     end
                  end
               end
            end
            ST_APPLY: begin
               op_q <= OP_ELEM;
               idx_q <= 2'h0;
               addr_q <= elem_base_i;
               state_q <= ST_REQ;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Received words and display-side outputs

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < tpx_pkg::CMD_WORDS; i++) begin
            cmd_q[i] <= tpx_pkg::WORD_ZERO;
         end
         copy_entry_prev_q <= tpx_pkg::WORD_ZERO;
         copy_type_prev_q <= tpx_pkg::WORD_ZERO;
         screen_o <= tpx_pkg::WORD_ZERO;
         screen_change_o <= 1'b0;
         backlight_o <= 1'b0;
         copy_start_o <= 1'b0;
         copy_type_o <= tpx_pkg::COPY_STRING;
         copy_entry_o <= 7'h00;
         elem_update_o <= 1'b0;
         elem_index_o <= 2'h0;
         elem_data_o <= tpx_pkg::WORD_ZERO;
      end else begin
         screen_change_o <= 1'b0;
         copy_start_o <= 1'b0;
         elem_update_o <= 1'b0;
         if (ack && op_q == OP_CMD) begin
            cmd_q[idx_q] <= link.rsp_rdata;
         end
         if (ack && op_q == OP_ELEM) begin
            elem_update_o <= 1'b1;
            elem_index_o <= idx_q;
            elem_data_o <= link.rsp_rdata;
         end
         if (state_q == ST_APPLY) begin
            if (scr_new) begin
               screen_o <= cmd_q[0];
               screen_change_o <= 1'b1;
            end
            copy_entry_prev_q <= cmd_q[1];
            copy_type_prev_q <= cmd_q[2];
            if ((cmd_q[1] != copy_entry_prev_q ||
                 cmd_q[2] != copy_type_prev_q) &&
                cmd_q[1] <= 16'(tpx_pkg::ENTRY_MAX)) begin
               copy_start_o <= 1'b1;
               copy_entry_o <= cmd_q[1][6:0];
               copy_type_o <= cmd_q[2][tpx_pkg::COPY_TYPE_BIT];
            end
            backlight_o <= cmd_q[3][tpx_pkg::CTRL_BACKLIGHT_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pending writes, report flags and strobes

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         num_pend_q <= 1'b0;
         str_pend_q <= 1'b0;
         key_pend_q <= 1'b0;
         num_entry_q <= 7'h00;
         str_entry_q <= 7'h00;
         num_val_q <= tpx_pkg::WORD_ZERO;
         str_val_q <= tpx_pkg::WORD_ZERO;
         key_code_q <= tpx_pkg::WORD_ZERO;
      end else begin
         if (ack && op_q == OP_NUMW) num_pend_q <= 1'b0;
         if (ack && op_q == OP_STRW) str_pend_q <= 1'b0;
         if (ack && op_q == OP_KEYW) key_pend_q <= 1'b0;
         if (num_key_valid_i && num_key_ready_o) begin
            num_pend_q <= 1'b1;
            num_entry_q <= num_key_entry_i;
            num_val_q <= num_key_value_i;
         end
         if (str_edit_valid_i && str_edit_ready_o) begin
            str_pend_q <= 1'b1;
            str_entry_q <= str_edit_entry_i;
            str_val_q <= str_edit_value_i;
         end
         if (sys_key_valid_i && sys_key_ready_o) begin
            key_pend_q <= 1'b1;
            key_code_q <= sys_key_code_i;
         end
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rpt0_pend_q <= 1'b0;
         rpt1_pend_q <= 1'b0;
         stat_pend_q <= 1'b0;
         rpt_entry_q <= 7'h00;
         strobe_q <= 2'h0;
         sent_q <= 2'h0;
         state_last_q <= 14'h0000;
      end else begin
         if (state_q == ST_IDLE && sel_go && sel_op == OP_RPT2) begin
            sent_q <= strobe_q;
            state_last_q <= state_bits_i;
         end
         if (ack && op_q == OP_RPT0) begin
            rpt0_pend_q <= 1'b0;
            strobe_q[tpx_pkg::STAT_SCR_STROBE_BIT] <= 1'b1;
         end
         if (ack && op_q == OP_RPT1) begin
            rpt1_pend_q <= 1'b0;
            strobe_q[tpx_pkg::STAT_NUM_STROBE_BIT] <= 1'b1;
         end
         if (ack && op_q == OP_RPT2) begin
            strobe_q <= strobe_q & ~sent_q;
            stat_pend_q <= |sent_q;
         end
         if (ack && (op_q == OP_RPT0 || op_q == OP_RPT1)) begin
            stat_pend_q <= 1'b1;
         end
         if (state_change) begin
            stat_pend_q <= 1'b1;
         end
         if (ack && op_q == OP_NUMW) begin
            rpt1_pend_q <= 1'b1;
            rpt_entry_q <= num_entry_q;
         end
         if (scr_new) begin
            rpt0_pend_q <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ---- hw/tpx_pkg.sv ----
// Shared constants for the terminal / controller status exchange.
// Assumes a 50 MHz clock and 16-bit controller memory words.
package tpx_pkg;

   localparam int WORD_W = 16;
   localparam int ENTRY_W = 7;
   localparam int STATE_W = 14;

   // Block sizes and word offsets
   localparam int CMD_WORDS = 4;
   localparam int RPT_WORDS = 3;
   localparam logic [15:0] CMD_SCREEN = 16'h0000;
   localparam logic [15:0] CMD_COPY_ENTRY = 16'h0001;
   localparam logic [15:0] CMD_COPY_TYPE = 16'h0002;
   localparam logic [15:0] CMD_CONTROL = 16'h0003;
   localparam logic [15:0] RPT_SCREEN = 16'h0000;
   localparam logic [15:0] RPT_ENTRY = 16'h0001;
   localparam logic [15:0] RPT_STATUS = 16'h0002;

   // Field positions
   localparam int CTRL_BACKLIGHT_BIT = 0;
   localparam int COPY_TYPE_BIT = 0;
   localparam int STAT_SCR_STROBE_BIT = 0;
   localparam int STAT_NUM_STROBE_BIT = 1;
   localparam int STAT_STATE_LSB = 2;

   // Copy types
   localparam logic COPY_STRING = 1'b0;
   localparam logic COPY_NUMERIC = 1'b1;
   localparam int ENTRY_MAX = 127;

   // Display element words polled after each command read
   localparam int ELEM_WORDS = 4;
   localparam logic [1:0] ELEM_LAST = 2'h3;

   // Poll period
   localparam int CLK_MHZ = 50;
   localparam int POLL_TIME_US = 10;
   localparam int POLL_CYCLES = POLL_TIME_US * CLK_MHZ;
   localparam logic [15:0] POLL_LAST = 16'(POLL_CYCLES - 1);

   // Controller memory and register bus
   localparam int MEM_DEPTH = 256;
   localparam int MEM_AW = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   localparam logic [15:0] WORD_ZERO = 16'h0000;

   function automatic logic [15:0] word_addr(input logic [15:0] base,
                                             input logic [15:0] off);
      word_addr = base + off;
   endfunction

endpackage

// ---- hw/tpx_link_if.sv ----
// Word link between the operator terminal and controller memory.
// The terminal issues word requests; the controller answers each one.
`timescale 1ns/1ps
`default_nettype none
interface tpx_link_if;
   logic req_valid;
   logic req_write;
   logic [15:0] req_addr;
   logic [15:0] req_wdata;
   logic req_ready;
   logic rsp_valid;
   logic [15:0] rsp_rdata;

   modport terminal (
      output req_valid, req_write, req_addr, req_wdata,
      input req_ready, rsp_valid, rsp_rdata
   );
   modport controller (
      input req_valid, req_write, req_addr, req_wdata,
      output req_ready, rsp_valid, rsp_rdata
   );
endinterface
`default_nettype wire

// ---- hw/tpx_controller.sv ----
// Controller end: word memory behind an AXI4-Lite slave, served to the link.
// Assumes the terminal issues one link request at a time.
`timescale 1ns/1ps
`default_nettype none
module tpx_controller (
   input wire logic clock_i,
   input wire logic reset_n_i,
   tpx_link_if.controller link,
   input wire logic [15:0] rpt_base_i,
   output logic scr_event_o,
   output logic num_event_o,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [15:0] mem_q [tpx_pkg::MEM_DEPTH];
   logic aw_hold_q, w_hold_q;
   logic [31:0] awaddr_q, wdata_q;
   logic [3:0] wstrb_q;
   logic axi_wr, aw_mapped, link_fire;
   logic [15:0] link_old, axi_old, axi_new;
   logic [tpx_pkg::MEM_AW-1:0] aw_idx, link_idx;

   function automatic logic mapped(input logic [31:0] a);
      mapped = (a[31:10] == 22'h00_0000);
   endfunction

   assign axi_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
   assign aw_mapped = mapped(awaddr_q);
   assign aw_idx = awaddr_q[9:2];
   assign link_idx = link.req_addr[tpx_pkg::MEM_AW-1:0];
   assign link_fire = link.req_valid && link.req_ready;
   assign link.req_ready = !axi_wr;
   assign s_axi_awready = !aw_hold_q;
   assign s_axi_wready = !w_hold_q;
   assign s_axi_arready = !s_axi_rvalid;
   assign link_old = mem_q[link_idx];
   assign axi_old = mem_q[aw_idx];
   assign axi_new = {wstrb_q[1] ? wdata_q[15:8] : axi_old[15:8],
                     wstrb_q[0] ? wdata_q[7:0] : axi_old[7:0]};

   ////////////////////////////////////////////////////////////////////////
   // Register bus

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= tpx_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (axi_wr) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= aw_mapped ? tpx_pkg::RESP_OKAY :
                           tpx_pkg::RESP_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= tpx_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         if (mapped(s_axi_araddr)) begin
            s_axi_rdata <= {16'h0000, mem_q[s_axi_araddr[9:2]]};
            s_axi_rresp <= tpx_pkg::RESP_OKAY;
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tpx_pkg::RESP_DECERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Memory: software writes any mapped word, terminal the report, numeric, string and key words

   always_ff @(posedge clock_i) begin
      if (axi_wr && aw_mapped) begin
         mem_q[aw_idx] <= axi_new;
      end else if (link_fire && link.req_write) begin
         mem_q[link_idx] <= link.req_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link answers and strobe watch

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         link.rsp_valid <= 1'b0;
         link.rsp_rdata <= tpx_pkg::WORD_ZERO;
      end else begin
         link.rsp_valid <= link_fire;
         if (link_fire) begin
            link.rsp_rdata <= link_old;
         end
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         scr_event_o <= 1'b0;
         num_event_o <= 1'b0;
      end else begin
         scr_event_o <= 1'b0;
         num_event_o <= 1'b0;
         if (link_fire && link.req_write && link.req_addr ==
             tpx_pkg::word_addr(rpt_base_i, tpx_pkg::RPT_STATUS)) begin
            scr_event_o <= link.req_wdata[tpx_pkg::STAT_SCR_STROBE_BIT] &&
               !link_old[tpx_pkg::STAT_SCR_STROBE_BIT];
            num_event_o <= link.req_wdata[tpx_pkg::STAT_NUM_STROBE_BIT] &&
               !link_old[tpx_pkg::STAT_NUM_STROBE_BIT];
         end
      end
   end

endmodule
`default_nettype wire

// ---- test/tpx_monitor.sv ----
// Link checker for the terminal / controller word exchange.
// Assumes both ends share clock_i and the bench's block bases.
`timescale 1ns/1ps
`default_nettype none
module tpx_monitor #(
   parameter logic [15:0] CMD_BASE = 16'h0010,
   parameter logic [15:0] RPT_BASE = 16'h0020
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [15:0] req_addr,
   input wire logic [15:0] req_wdata,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic [15:0] rsp_rdata
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   logic tk;
   logic st_w;
   assign tk = req_valid && req_ready;
   assign st_w = tk && req_write && req_addr == RPT_BASE + tpx_pkg::RPT_STATUS;
   ////////////////////////////////////////////////////////////////////////
   a_req_hold: assert property (req_valid && !req_ready |=> req_valid
      && $stable(req_addr) && $stable(req_write) && $stable(req_wdata))
      else $error("link request changed while stalled");
   a_rsp_next: assert property (tk |=> rsp_valid)
      else $error("link answer not one cycle after request");
   a_rsp_cause: assert property (rsp_valid |-> $past(tk))
      else $error("link answer without request");
   a_rsp_single: assert property (rsp_valid |-> !req_valid ##1 !rsp_valid)
      else $error("link answer overlaps or lasts too long");
   a_cmd_order: assert property (tk && !req_write && req_addr >= CMD_BASE
      && req_addr < CMD_BASE + 16'h0003 |=> ##1 (req_valid && !req_write
      && req_addr == $past(req_addr, 2) + 16'h0001))
      else $error("command block not read as consecutive words");
   a_cmd_no_write: assert property (tk && req_write |->
      !(req_addr >= CMD_BASE && req_addr <= CMD_BASE + 16'h0003))
      else $error("terminal wrote into command block");
   a_scr_status: assert property (tk && req_write && req_addr == RPT_BASE
      |-> ##[1:60] (st_w && req_wdata[0]))
      else $error("screen report without screen strobe");
   a_num_status: assert property (tk && req_write
      && req_addr == RPT_BASE + 16'h0001 |-> ##[1:60] (st_w && req_wdata[1]))
      else $error("entry report without numeric strobe");
   a_scr_clear: assert property (st_w && req_wdata[0]
      |-> ##[1:60] (st_w && !req_wdata[0]))
      else $error("screen strobe not returned to zero");
   a_num_clear: assert property (st_w && req_wdata[1]
      |-> ##[1:60] (st_w && !req_wdata[1]))
      else $error("numeric strobe not returned to zero");
   c_scr: cover property (st_w && req_wdata[0]);
   c_num: cover property (st_w && req_wdata[1]);
   c_cmd: cover property (tk && req_addr == CMD_BASE + 16'h0003);
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench joining terminal and controller over the link.
// Assumes a 50 MHz clock_i and AXI4-Lite access to controller memory.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [15:0] CMD = 16'h0010;
   localparam logic [15:0] RPT = 16'h0020;
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [15:0] cmd_b = CMD, rpt_b = RPT, elm_b = 16'h0030;
   logic [15:0] num_b = 16'h0040, str_b = 16'h0080, key_b = 16'h00F0;
   logic [13:0] st_bits = 14'h0000;
   logic [2:0] u_vld = 3'h0;
   wire [2:0] u_rdy;
   logic [6:0] u_ent = 7'h00;
   logic [15:0] u_val = 16'h0000;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic scr_ev, num_ev, scr_chg, bl, cp_go, cp_ty, el_up;
   logic [15:0] scr, el_d;
   logic [6:0] cp_e;
   logic [1:0] el_i;
   logic [15:0] el_exp [4];
   int miscompares = 0, n_tests = 0, cyc = 0, seed = 95947;
   int n_scr = 0, n_sev = 0, n_num = 0, n_cp = 0;
   tpx_link_if lnk ();
   tpx_controller tpx_controller_i (.clock_i, .reset_n_i, .link(lnk),
      .rpt_base_i(rpt_b), .scr_event_o(scr_ev), .num_event_o(num_ev),
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   tpx_terminal tpx_terminal_i (.clock_i, .reset_n_i, .link(lnk),
      .cmd_base_i(cmd_b), .rpt_base_i(rpt_b), .elem_base_i(elm_b),
      .num_base_i(num_b), .str_base_i(str_b), .key_addr_i(key_b),
      .state_bits_i(st_bits), .num_key_valid_i(u_vld[0]),
      .num_key_entry_i(u_ent), .num_key_value_i(u_val),
      .num_key_ready_o(u_rdy[0]), .str_edit_valid_i(u_vld[1]),
      .str_edit_entry_i(u_ent), .str_edit_value_i(u_val),
      .str_edit_ready_o(u_rdy[1]), .sys_key_valid_i(u_vld[2]),
      .sys_key_code_i(u_val), .sys_key_ready_o(u_rdy[2]), .screen_o(scr),
      .screen_change_o(scr_chg), .backlight_o(bl), .copy_start_o(cp_go),
      .copy_type_o(cp_ty), .copy_entry_o(cp_e), .elem_update_o(el_up),
      .elem_index_o(el_i), .elem_data_o(el_d));
   tpx_monitor #(.CMD_BASE(CMD), .RPT_BASE(RPT)) tpx_monitor_i (.clock_i,
      .reset_n_i, .req_valid(lnk.req_valid), .req_write(lnk.req_write),
      .req_addr(lnk.req_addr), .req_wdata(lnk.req_wdata),
      .req_ready(lnk.req_ready), .rsp_valid(lnk.rsp_valid),
      .rsp_rdata(lnk.rsp_rdata));
   always #10 clock_i = ~clock_i;
   ////////////////////////////////////////////////////////////////////////
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, s);
         miscompares++;
      end
   endtask
   task finish_test();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task wr(input logic [15:0] a, input logic [15:0] v, output logic [1:0] r);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= {14'h0, a, 2'h0};
      s_axi_wdata <= {16'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clock_i);
         if (s_axi_awready && !aw) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !w) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clock_i); while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask
   task rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= {14'h0, a, 2'h0};
      s_axi_arvalid <= 1'b1;
      do @(posedge clock_i); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clock_i); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   // Offer one operator action and wait until ready returns: word write acked (and entry report, if numeric; status not awaited)
   task usr(input int g, input logic [6:0] e, input logic [15:0] v);
      u_ent <= e;
      u_val <= v;
      u_vld[g] <= 1'b1;
      do @(posedge clock_i); while (!u_rdy[g]);
      u_vld[g] <= 1'b0;
      do @(posedge clock_i); while (!u_rdy[g]);
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      n_scr <= n_scr + int'(scr_chg);
      n_sev <= n_sev + int'(scr_ev);
      n_num <= n_num + int'(num_ev);
      n_cp <= n_cp + int'(cp_go);
      if (el_up) chk("elem data", 32'(el_exp[el_i]), 32'(el_d));
      if (cyc == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      logic [15:0] ent [3];
      logic [31:0] d;
      logic [1:0] r;
      logic [15:0] s, v;
      logic [6:0] e;
      int k, n0, n1;
      ent = '{16'h007F, 16'h0000, 16'h0080};
      repeat (8) @(posedge clock_i);
      reset_n_i <= 1'b1;
      st_bits <= 14'($random(seed));
      for (k = 0; k < 4; k++) begin
         el_exp[k] = 16'($random(seed));
         wr(elm_b + 16'(k), el_exp[k], r);
         wr(cmd_b + 16'(k), 16'h0000, r);
      end
      for (k = 0; k < 3; k++) begin
         do @(posedge clock_i); while (!(el_up && el_i == 2'h3));
         s = 16'(k + 1) | (16'($random(seed)) & 16'h00F0);
         n0 = n_cp;
         n1 = n_sev;
         wr(cmd_b + 16'h0001, ent[k], r);
         wr(cmd_b + 16'h0002, 16'(k == 0 || k == 2), r);
         wr(cmd_b + 16'h0003, 16'(k != 1), r);
         wr(cmd_b, s, r);
         while (n_sev == n1) @(posedge clock_i);
         chk("screen", 32'(s), 32'(scr));
         chk("screen changes", 32'(k + 1), 32'(n_scr));
         chk("backlight", 32'(k != 1), 32'(bl));
         chk("copies", 32'(k < 2), 32'(n_cp - n0));
         if (k < 2) chk("copy entry", 32'(ent[k]), 32'(cp_e));
         if (k < 2) chk("copy type", 32'(k == 0), 32'(cp_ty));
         rd(rpt_b, d, r);
         chk("report screen", 32'(s), d);
      end
      for (k = 0; k < 3; k++) begin
         e = (k == 0) ? 7'h3F : (7'($random(seed)) & 7'h3F);
         v = 16'($random(seed));
         usr(0, e, v);
         rd(num_b + 16'(e), d, r);
         chk("numeric word", 32'(v), d);
         rd(rpt_b + 16'h0001, d, r);
         chk("report entry", 32'(e), d);
         do rd(rpt_b + 16'h0002, d, r); while (d[1] !== 1'b0);
      end
      chk("numeric events", 32'h0000_0003, 32'(n_num));
      v = 16'($random(seed));
      usr(1, 7'h21, v);
      rd(str_b + 16'h0021, d, r);
      chk("string word", 32'(v), d);
      rd(rpt_b + 16'h0001, d, r);
      chk("entry after string", 32'(e), d);
      v = 16'($random(seed));
      usr(2, 7'h00, v);
      rd(key_b, d, r);
      chk("system key", 32'(v), d);
      chk("numeric events", 32'h0000_0003, 32'(n_num));
      do rd(rpt_b + 16'h0002, d, r); while (d[0] !== 1'b0);
      chk("state bits", {16'h0, st_bits, 2'h0}, d);
      wr(16'h0100, 16'h5A5A, r);
      chk("unmapped write", 32'(tpx_pkg::RESP_DECERR), 32'(r));
      rd(16'h0100, d, r);
      chk("unmapped read", 32'(tpx_pkg::RESP_DECERR), 32'(r));
      chk("unmapped data", 32'h0000_0000, d);
      finish_test();
   end
endmodule
`default_nettype wire
